// ==== src/ttc_temp_count_thermostat.sv ====
/*
 temperature counter, slope accumulator, thermostat and register port.
 assumes both oscillators arrive as asynchronous levels and that the register
 master keeps strobes one cycle long and never both at once.
*/
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "ttc_regs.svh"

module ttc_temp_count_thermostat
   import ttc_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic lowTcOsc,
   input wire logic highTcOsc,
   input wire logic [3:0] addr,
   input wire logic [15:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [15:0] rdData,
   input wire logic serLoad,
   input wire logic serShift,
   output logic serBit,
   output logic thermostatOut
);

   // ---------------------------------------------------------------
   // oscillator synchronisers and edge detection
   // ---------------------------------------------------------------
   logic lowMeta, lowSync, lowLast;
   logic highMeta, highSync, highLast;

   always_ff @(posedge clock) begin
      if (srst) begin
         lowMeta <= 1'b0;
         lowSync <= 1'b0;
         lowLast <= 1'b0;
         highMeta <= 1'b0;
         highSync <= 1'b0;
         highLast <= 1'b0;
      end else begin
         lowMeta <= lowTcOsc;
         lowSync <= lowMeta;
         lowLast <= lowSync;
         highMeta <= highTcOsc;
         highSync <= highMeta;
         highLast <= highSync;
      end
   end

   wire fastEdge = lowSync & ~lowLast;
   wire gateEdge = highSync & ~highLast;

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   logic singleMode, outPolarity;
   ttc_temp_t highTrip, lowTrip;

   wire wrConfig = wrStrobe && (addr == `TTC_ADDR_CONFIG);
   wire wrHigh = wrStrobe && (addr == `TTC_ADDR_HIGH_TRIP);
   wire wrLow = wrStrobe && (addr == `TTC_ADDR_LOW_TRIP);
   wire wrCmd = wrStrobe && (addr == `TTC_ADDR_COMMAND);
   wire startCmd = wrCmd && wrData[`TTC_CMD_START];
   wire slopeCmd = wrCmd && wrData[`TTC_CMD_SLOPE];
   wire stopCmd = wrCmd && wrData[`TTC_CMD_STOP];

   always_ff @(posedge clock) begin
      if (srst) begin
         singleMode <= `TTC_CFG_SINGLE_RST;
         outPolarity <= `TTC_CFG_POLARITY_RST;
         highTrip <= `TTC_HIGH_TRIP_RST;
         lowTrip <= `TTC_LOW_TRIP_RST;
      end else begin
         if (wrConfig) begin
            singleMode <= wrData[`TTC_CFG_SINGLE];
            outPolarity <= wrData[`TTC_CFG_POLARITY];
         end
         if (wrHigh) begin
            highTrip <= wrData[8:0];
         end
         if (wrLow) begin
            lowTrip <= wrData[8:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // conversion engine
   // ---------------------------------------------------------------
   ttc_state_t state;
   logic [15:0] downCount, slopeAcc, countReg;
   logic [7:0] gateCount;
   ttc_temp_t tempAcc, tempOut;
   logic convDone, thermoActive;

   wire inConv = (state == TTC_CONV);
   wire beginConv = (state == TTC_IDLE) && !stopCmd && (startCmd || !singleMode);
   wire gateClose = inConv && gateEdge && (gateCount == `TTC_GATE_EDGES - 8'h01);
   wire underflow = inConv && !gateClose && fastEdge && (downCount == 16'h0001);
   wire atMax = (tempAcc == `TTC_TEMP_MAX);
   wire [15:0] nextSlope = slopeAcc + `TTC_SLOPE_STEP;
   wire restart = gateClose && !singleMode && !stopCmd;

   always_ff @(posedge clock) begin
      if (srst) begin
         state <= TTC_IDLE;
         downCount <= `TTC_BASE_COUNT;
         slopeAcc <= `TTC_SLOPE_BASE;
         gateCount <= 8'h00;
         tempAcc <= `TTC_TEMP_MIN;
      end else if (beginConv || restart) begin
         state <= TTC_CONV;
         downCount <= `TTC_BASE_COUNT;
         tempAcc <= `TTC_TEMP_MIN;
         slopeAcc <= `TTC_SLOPE_BASE;
         gateCount <= 8'h00;
      end else if (gateClose || (inConv && stopCmd)) begin
         state <= TTC_IDLE;
      end else if (inConv) begin
         if (gateEdge) begin
            gateCount <= gateCount + 8'h01;
         end
         if (underflow) begin
            slopeAcc <= nextSlope;
            downCount <= nextSlope;
            if (!atMax) begin
               tempAcc <= tempAcc + 9'sh001;
            end
         end else if (fastEdge) begin
            downCount <= downCount - 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // results, done flag and thermostat
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         tempOut <= `TTC_TEMP_MIN;
         countReg <= 16'h0000;
         convDone <= 1'b0;
         thermoActive <= 1'b0;
         thermostatOut <= ~`TTC_CFG_POLARITY_RST;
      end else begin
         if (gateClose) begin
            tempOut <= tempAcc;
            countReg <= downCount;
            if (tempAcc >= highTrip) begin
               thermoActive <= 1'b1;
            end else if (tempAcc < lowTrip) begin
               thermoActive <= 1'b0;
            end
         end else if (slopeCmd) begin
            countReg <= slopeAcc;
         end
         if (beginConv || restart) begin
            convDone <= 1'b0;
         end else if (gateClose) begin
            convDone <= 1'b1;
         end
         thermostatOut <= outPolarity ? thermoActive : ~thermoActive;
      end
   end

   // ---------------------------------------------------------------
   // temperature word and serial shifter
   // ---------------------------------------------------------------
   wire [15:0] tempWord = {tempOut[8:1], tempOut[0], 7'h00};
   logic [15:0] serShiftReg;

   always_ff @(posedge clock) begin
      if (srst) begin
         serShiftReg <= 16'h0000;
      end else if (serLoad) begin
         serShiftReg <= tempWord;
      end else if (serShift) begin
         serShiftReg <= {serShiftReg[14:0], 1'b0};
      end
   end

   assign serBit = serShiftReg[15];

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   wire [15:0] configWord = {8'h00, convDone, 5'h00, outPolarity, singleMode};
   wire [15:0] rdMux =
      (addr == `TTC_ADDR_CONFIG) ? configWord :
      (addr == `TTC_ADDR_HIGH_TRIP) ? {{7{highTrip[8]}}, highTrip} :
      (addr == `TTC_ADDR_LOW_TRIP) ? {{7{lowTrip[8]}}, lowTrip} :
      (addr == `TTC_ADDR_TEMP) ? tempWord :
      (addr == `TTC_ADDR_COUNT) ? countReg :
      16'h0000;

   always_ff @(posedge clock) begin
      if (srst) begin
         rdData <= 16'h0000;
      end else begin
         rdData <= rdStrobe ? rdMux : 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_preset;
      @(posedge clock) disable iff (srst)
      (beginConv || restart) |=> (downCount == `TTC_BASE_COUNT) && (tempAcc == `TTC_TEMP_MIN);
   endproperty
   a_preset: assert property (p_preset) else $error("conversion preset wrong");

   property p_increment;
      @(posedge clock) disable iff (srst)
      (underflow && !atMax && !stopCmd) |=> tempAcc == $past(tempAcc) + 9'sh001;
   endproperty
   a_increment: assert property (p_increment) else $error("temperature not stepped");

   property p_reload;
      @(posedge clock) disable iff (srst)
      (underflow && !stopCmd) |=> (downCount == slopeAcc) && (slopeAcc != $past(slopeAcc));
   endproperty
   a_reload: assert property (p_reload) else $error("counter not reloaded from slope");

   property p_slope;
      @(posedge clock) disable iff (srst)
      (underflow && !stopCmd) |=> slopeAcc == $past(slopeAcc) + `TTC_SLOPE_STEP;
   endproperty
   a_slope: assert property (p_slope) else $error("slope accumulator not advanced");

   property p_span;
      @(posedge clock) disable iff (srst)
      (tempAcc >= $signed(`TTC_TEMP_MIN)) && (tempAcc <= $signed(`TTC_TEMP_MAX));
   endproperty
   a_span: assert property (p_span) else $error("temperature outside span");

   property p_word;
      @(posedge clock) disable iff (srst)
      (tempWord[6:0] == 7'h00) && (tempWord[15:7] == tempOut);
   endproperty
   a_word: assert property (p_word) else $error("temperature word malformed");

   property p_residual;
      @(posedge clock) disable iff (srst)
      gateClose |=> (countReg == $past(downCount)) && (tempOut == $past(tempAcc));
   endproperty
   a_residual: assert property (p_residual) else $error("residual or result not latched");

   property p_slope_read;
      @(posedge clock) disable iff (srst)
      (slopeCmd && !gateClose) |=> countReg == $past(slopeAcc);
   endproperty
   a_slope_read: assert property (p_slope_read) else $error("slope not copied");

   property p_thermo_only_at_end;
      @(posedge clock) disable iff (srst)
      !gateClose |=> $stable(thermoActive);
   endproperty
   a_thermo_only_at_end: assert property (p_thermo_only_at_end) else $error("moved");

   property p_thermo_trip;
      @(posedge clock) disable iff (srst)
      (gateClose && (tempAcc >= highTrip)) |=> thermoActive;
   endproperty
   a_thermo_trip: assert property (p_thermo_trip) else $error("high trip missed");

   property p_polarity;
      @(posedge clock) disable iff (srst)
      ##1 thermostatOut == ($past(outPolarity) ? $past(thermoActive) : !$past(thermoActive));
   endproperty
   a_polarity: assert property (p_polarity) else $error("thermostat level wrong");

   property p_single;
      @(posedge clock) disable iff (srst)
      (gateClose && singleMode) |=> (state == TTC_IDLE) ##1 (inConv == $past(startCmd));
   endproperty
   a_single: assert property (p_single) else $error("single conversion mode broken");

   property p_done;
      @(posedge clock) disable iff (srst)
      (inConv && !$past(gateClose)) |-> !convDone;
   endproperty
   a_done: assert property (p_done) else $error("done high during conversion");

   property p_msb_first;
      @(posedge clock) disable iff (srst)
      serLoad |=> (serBit == $past(tempWord[15])) ##0 (serShiftReg == $past(tempWord));
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("serial word not msb first");

   property p_read_once;
      @(posedge clock) disable iff (srst)
      !rdStrobe |=> rdData == 16'h0000;
   endproperty
   a_read_once: assert property (p_read_once) else $error("read data outside its cycle");

   property p_gate_count;
      @(posedge clock) disable iff (srst)
      (inConv && gateEdge && !gateClose && !stopCmd) |=> gateCount == $past(gateCount) + 8'h01;
   endproperty
   a_gate_count: assert property (p_gate_count) else $error("gate edge not counted");

   property p_count_down;
      @(posedge clock) disable iff (srst)
      (inConv && fastEdge && !underflow && !gateClose && !stopCmd)
         |=> downCount == $past(downCount) - 16'h0001;
   endproperty
   a_count_down: assert property (p_count_down) else $error("counter not decremented");

   property p_thermo_release;
      @(posedge clock) disable iff (srst)
      (gateClose && (tempAcc < lowTrip) && (tempAcc < highTrip)) |=> !thermoActive;
   endproperty
   a_thermo_release: assert property (p_thermo_release) else $error("low trip missed");

   property p_thermo_hold;
      @(posedge clock) disable iff (srst)
      (gateClose && (tempAcc >= lowTrip) && (tempAcc < highTrip)) |=> $stable(thermoActive);
   endproperty
   a_thermo_hold: assert property (p_thermo_hold) else $error("hysteresis broken");

   property p_restart;
      @(posedge clock) disable iff (srst)
      (gateClose && !singleMode && !stopCmd) |=> inConv && (gateCount == 8'h00) && !convDone;
   endproperty
   a_restart: assert property (p_restart) else $error("continuous mode stalled");

   property p_done_set;
      @(posedge clock) disable iff (srst)
      (gateClose && singleMode) |=> convDone;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done not set");

   property p_config_write;
      @(posedge clock) disable iff (srst)
      wrConfig |=> (outPolarity == $past(wrData[`TTC_CFG_POLARITY]))
         && (singleMode == $past(wrData[`TTC_CFG_SINGLE]));
   endproperty
   a_config_write: assert property (p_config_write) else $error("config write lost");

   c_underflow: cover property (@(posedge clock) disable iff (srst) underflow);
   c_gate_close: cover property (@(posedge clock) disable iff (srst) gateClose ##1 convDone);
   c_trip: cover property (@(posedge clock) disable iff (srst) $rose(thermoActive));
   c_slope_read: cover property (@(posedge clock) disable iff (srst) slopeCmd ##1 rdStrobe);
   c_release: cover property (@(posedge clock) disable iff (srst) $fell(thermoActive));

endmodule // ttc_temp_count_thermostat

// ==== src/ttc_regs.svh ====
/*
 constants of the temperature counter and thermostat: register offsets, field
 positions, reset values and measurement counts.
 assumes a plain register port with 4-bit addresses and 16-bit data.
*/
// Contract
// - count low-tc oscillator during high-tc gate window
// - conversion start presets counter and temperature -55
// - counter reaching zero in window increments temperature
// - underflow reloads counter from slope accumulator
// - slope accumulator varies counts per degree
// - result is 9-bit two's complement, half degree
// - span -55 to +125, saturated
// - word encoding 1900h, FF80h, C900h
// - temperature word shifted out msb first
// - one or two bytes, master may stop
// - second byte holds half bit, rest zero
// - counter read returns residual at gate end
// - slope read copies accumulator into count register
// - thermostat updates only when conversion finishes
// - active at or above high, until below low
// - user chooses asserted level of thermostat output
// - polarity 1 active high, 0 active low
// - continuous conversions, or one per start request
// - done reads 1 complete, 0 in progress; in continuous mode the restart clears it as the gate closes, so it stays 0
`ifndef TTC_REGS_SVH
`define TTC_REGS_SVH

// register offsets
`define TTC_ADDR_CONFIG 4'h0
`define TTC_ADDR_HIGH_TRIP 4'h1
`define TTC_ADDR_LOW_TRIP 4'h2
`define TTC_ADDR_TEMP 4'h3
`define TTC_ADDR_COUNT 4'h4
`define TTC_ADDR_COMMAND 4'h5

// configuration fields
`define TTC_CFG_SINGLE 0
`define TTC_CFG_POLARITY 1
`define TTC_CFG_DONE 7

// command fields
`define TTC_CMD_START 0
`define TTC_CMD_SLOPE 1
`define TTC_CMD_STOP 2

// reset values
`define TTC_CFG_SINGLE_RST 1'b0
`define TTC_CFG_POLARITY_RST 1'b1
`define TTC_HIGH_TRIP_RST 9'h050
`define TTC_LOW_TRIP_RST 9'h03C

// measurement values, temperature in half degrees
`define TTC_TEMP_MIN 9'h192
`define TTC_TEMP_MAX 9'h0FA
`define TTC_BASE_COUNT 16'h0100
`define TTC_SLOPE_BASE 16'h0040
`define TTC_SLOPE_STEP 16'h0001
`define TTC_GATE_EDGES 8'h40

`endif

// ==== src/ttc_pkg.sv ====
/*
 types of the temperature counter and thermostat.
 assumes nothing of its surroundings.
*/
package ttc_pkg;
   typedef enum logic {TTC_IDLE, TTC_CONV} ttc_state_t;
   typedef logic signed [8:0] ttc_temp_t;
endpackage

// ==== bench/ttc_serial_master.sv ====
/*
 far-side serial master: loads the temperature word and shifts it out.
 assumes serBit shows the shifter msb in the cycle after each load or shift.
*/
`timescale 1ns/1ps

module ttc_serial_master (
   input wire logic clock,
   input wire logic serBit,
   output logic serLoad,
   output logic serShift
);
   initial begin
      serLoad = 1'b0;
      serShift = 1'b0;
   end

   // ----------------------------------------
   // word transfer
   // ----------------------------------------
   // msb first; a one-byte read stops after eight bits
   task automatic readBits(input int nBits, output logic [15:0] word);
      word = 16'h0000;
      @(posedge clock) serLoad <= 1'b1;
      @(posedge clock) serLoad <= 1'b0;
      for (int i = 0; i < nBits; i++) begin
         @(negedge clock) word[15 - i] = serBit;
         @(posedge clock) serShift <= 1'b1;
         @(posedge clock) serShift <= 1'b0;
      end
   endtask
endmodule // ttc_serial_master

// ==== bench/tb_top.sv ====
/*
 self-checking bench of the temperature counter and thermostat.
 assumes the oscillators are slow enough for the block's synchronisers.
*/
`timescale 1ns/1ps
`include "ttc_regs.svh"

module tb_top import ttc_pkg::*;;
   typedef struct {
      int n;
      ttc_temp_t temp;
      logic [15:0] count;
      logic [15:0] slope;
      logic active;
   } ttc_row_t;

   logic clock = 1'b0;
   logic srst = 1'b1;
   logic lowTcOsc = 1'b0;
   logic highTcOsc = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wrData = 16'h0000;
   logic wrStrobe = 1'b0;
   logic rdStrobe = 1'b0;
   logic [15:0] rdData;
   logic serLoad;
   logic serShift;
   logic serBit;
   logic thermostatOut;
   int badCount = 0;
   int checkCount = 0;
   // trips: high -108, low -109 half degrees
   ttc_row_t rows [6] = '{
      '{0, 9'h192, 16'h0100, 16'h0040, 1'b0},
      '{321, 9'h194, 16'h0042, 16'h0042, 1'b1},
      '{256, 9'h193, 16'h0041, 16'h0041, 1'b1},
      '{0, 9'h192, 16'h0100, 16'h0040, 1'b0},
      '{257, 9'h193, 16'h0040, 16'h0041, 1'b0},
      '{255, 9'h192, 16'h0001, 16'h0040, 1'b0}
   };

   always #2.5 clock = ~clock;

   ttc_temp_count_thermostat u_ttc_temp_count_thermostat (
      .clock(clock), .srst(srst), .lowTcOsc(lowTcOsc), .highTcOsc(highTcOsc),
      .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
      .rdData(rdData), .serLoad(serLoad), .serShift(serShift), .serBit(serBit),
      .thermostatOut(thermostatOut)
   );

   ttc_serial_master u_ttc_serial_master (
      .clock(clock), .serBit(serBit), .serLoad(serLoad), .serShift(serShift)
   );

   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic checkWord(input logic [15:0] exp, input logic [15:0] got);
      checkCount++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clock) wrStrobe <= 1'b0;
   endtask

   task automatic regRead(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clock) rdStrobe <= 1'b0;
      @(negedge clock) d = rdData;
   endtask

   // pulses two cycles high and two low, then lets the synchronisers drain
   task automatic oscPulses(input logic gate, input int n);
      for (int i = 0; i < n; i++) begin
         repeat (2) @(posedge clock);
         if (gate)
            highTcOsc <= 1'b1;
         else
            lowTcOsc <= 1'b1;
         repeat (2) @(posedge clock);
         highTcOsc <= 1'b0;
         lowTcOsc <= 1'b0;
      end
      repeat (6) @(posedge clock);
   endtask

   task automatic closeOut;
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic waitDone;
      logic [15:0] cfg;
      for (int i = 0; i < 40; i++) begin
         regRead(`TTC_ADDR_CONFIG, cfg);
         if (cfg[`TTC_CFG_DONE] === 1'b1)
            return;
      end
      badCount++;
      closeOut();
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [15:0] word;
      logic [15:0] prevWord;
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      regWrite(`TTC_ADDR_CONFIG, 16'h0003);
      regWrite(`TTC_ADDR_COMMAND, 16'h0004);
      regWrite(`TTC_ADDR_HIGH_TRIP, 16'h0194);
      regWrite(`TTC_ADDR_LOW_TRIP, 16'h0193);
      regRead(`TTC_ADDR_HIGH_TRIP, word);
      checkWord(16'hFF94, word);
      foreach (rows[i]) begin
         regWrite(`TTC_ADDR_COMMAND, 16'h0001);
         oscPulses(1'b0, rows[i].n);
         regRead(`TTC_ADDR_CONFIG, word);
         checkWord(16'h0000, {15'h0000, word[`TTC_CFG_DONE]});
         if (i > 0) begin
            regRead(`TTC_ADDR_TEMP, word);
            checkWord(prevWord, word);
            checkWord({15'h0000, rows[i - 1].active}, {15'h0000, thermostatOut});
         end
         oscPulses(1'b1, 64);
         waitDone();
         prevWord = {rows[i].temp, 7'h00};
         regRead(`TTC_ADDR_TEMP, word);
         checkWord(prevWord, word);
         regRead(`TTC_ADDR_COUNT, word);
         checkWord(rows[i].count, word);
         regWrite(`TTC_ADDR_COMMAND, 16'h0002);
         regRead(`TTC_ADDR_COUNT, word);
         checkWord(rows[i].slope, word);
         u_ttc_serial_master.readBits(16, word);
         checkWord(prevWord, word);
         u_ttc_serial_master.readBits(8, word);
         checkWord({prevWord[15:8], 8'h00}, word);
         @(negedge clock);
         checkWord({15'h0000, rows[i].active}, {15'h0000, thermostatOut});
      end
      // active-low output while inactive reads high
      regWrite(`TTC_ADDR_CONFIG, 16'h0001);
      regWrite(`TTC_ADDR_COMMAND, 16'h0001);
      oscPulses(1'b1, 64);
      waitDone();
      checkWord(16'h0001, {15'h0000, thermostatOut});
      // continuous mode restarts without a start request
      regWrite(`TTC_ADDR_CONFIG, 16'h0002);
      oscPulses(1'b0, 256);
      oscPulses(1'b1, 64);
      regRead(`TTC_ADDR_TEMP, word);
      checkWord(16'hC980, word);
      oscPulses(1'b1, 64);
      regRead(`TTC_ADDR_TEMP, word);
      checkWord(16'hC900, word);
      regRead(4'hF, word);
      checkWord(16'h0000, word);
      // reset in mid-run restores the defaults
      @(posedge clock) srst <= 1'b1;
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      regRead(`TTC_ADDR_CONFIG, word);
      checkWord(16'h0002, word & 16'h0083);
      checkWord(16'h0000, {15'h0000, thermostatOut});
      regRead(`TTC_ADDR_HIGH_TRIP, word);
      checkWord(16'h0050, word);
      regRead(`TTC_ADDR_LOW_TRIP, word);
      checkWord(16'h003C, word);
      closeOut();
   end
endmodule // tb_top
